// ---- rst_seq_defs.vh ----
/*
 * Timing counts, reset values and encodings for the reset and clock
 * start-up sequencer. Assumes a 20 MHz oscillator clock on the module.
 */
`ifndef RST_SEQ_DEFS_VH
`define RST_SEQ_DEFS_VH

// ----------------------------------------------------------------------
// Clock rate and times
// ----------------------------------------------------------------------
`define CLOCK_MHZ        20
`define OSC_START_NS     3000
`define DRIVE_US         600
// Counts sized to the 16-bit counters; recompute if CLOCK_MHZ changes
`define OSC_START_CYC    16'h003c
`define DRIVE_CYC        16'h2ee0
`define WDOG_CYC         16'h0200
`define BUS_DELAY_CYC    16'h0020
`define PIN_LOW_MIN_CYC  16'h0020
`define STRAP_HOLD_SYS   16'h03e8
`define LOCK_MIN_CYC     16'h2710

// ----------------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------------
`define SYSTEM_CLOCK_DIVIDE_SELECT_RST       2'h0
`define SYSTEM_CLOCK_DIVIDE_SELECT_DIV4      2'h0
`define SYSTEM_CLOCK_DIVIDE_SELECT_DIV2      2'h2
`define SYSTEM_CLOCK_DIVIDE_SELECT_DIV1      2'h3
`define CODIV_RST        2'h0
`define CODIV_DIV4       2'h0
`define CODIV_DIV2       2'h1
`define PLLM_RST         4'h0
`define MODE_DIV4        2'h0
`define MODE_DIV2        2'h1
`define MODE_DIV1        2'h2
`define MODE_PLL         2'h3

`endif

// ---- reset_clock_sequencer.v ----
/*
 * Reset and clock start-up sequencer: power-on reset, reset pin drive
 * and release, bus-valid delay, strap capture, clock divide defaults,
 * PLL relock and a glitch-free clock output pin.
 * Assumes resetn comes from the power-on supervisor and that the pin,
 * strap and brown-out inputs are asynchronous to clock.
 */
// Functional notes
// - System clock runs at oscillator divided by 4 after power-up.
// - Clock-output divider resets to 0 (/4): pin rate oscillator/16.
// - Boot step sets system divide select to /1: pin rate oscillator/4.
// - Clock output stays off the pin until user enables it.
// - Device-driven reset pulse lasts 600 us; a watchdog reset drives it for 512 cycles.
// - Bus activity valid 32 oscillator cycles after reset pin high.
// - Power-on reset generated internally; external pin optional.
// - Pin pulls enabled only while brown-out reset is high.
// - Multiplier write starts lock phase at oscillator divided by 2.
// - After lock completes, system clock takes the multiplied rate.
// - Multiplier 0x4 gives twice, 0x8 four times the oscillator.
// - All outputs come from flops on the one internal clock.
// - Outputs glitch-free through power transitions, except named pins.
// - Oscillator trusted only 3 us after start-up.
// - Lock period at least 10,000 cycles on internal oscillators.
`timescale 1ns/100ps
`default_nettype none
`include "rst_seq_defs.vh"

module reset_clock_sequencer #(
    parameter        GPIO_W      = 8,
    parameter        BOOT_W      = 2,
    parameter [7:0]  UNPROT_MASK = 8'h00,
    parameter [15:0] DRIVE_CYC   = `DRIVE_CYC
) (
    // Clock and power-on reset
    input  wire              clock,
    input  wire              resetn,
    // Reset pin, open drain
    input  wire              reset_pin_n_in,
    output reg               reset_pin_n_out,
    output reg               reset_pin_n_oe_n,
    // Supervisor and reset requests
    input  wire              brownout_reset,
    input  wire              watchdog_req,
    input  wire              soft_reset_req,
    // Boot-mode straps
    input  wire [BOOT_W-1:0] boot_mode_pins,
    output reg  [BOOT_W-1:0] boot_mode_q,
    output reg               boot_valid_q,
    // Clock configuration from user code
    input  wire              system_clock_divide_select_wr,
    input  wire [1:0]        system_clock_divide_select_in,
    input  wire              codiv_wr,
    input  wire [1:0]        codiv_in,
    input  wire              coen_wr,
    input  wire              coen_in,
    input  wire              pllm_wr,
    input  wire [3:0]        pllm_in,
    input  wire [15:0]       lock_prd_in,
    input  wire              intosc_sel,
    // Clock status and clock output pin
    output reg  [1:0]        sysclk_mode_q,
    output reg  [2:0]        pll_ratio_q,
    output reg               pll_locking_q,
    output reg               clock_output_pin,
    output reg               clock_output_oe_n,
    // Core status
    output reg               bus_valid_q,
    output reg               pull_enable_q,
    // General-purpose outputs
    input  wire [GPIO_W-1:0] gpio_in,
    input  wire [GPIO_W-1:0] gpio_oe_n_in,
    output reg  [GPIO_W-1:0] gpio_out,
    output reg  [GPIO_W-1:0] gpio_oe_n
);

    // ------------------------------------------------------------------
    // States and constants
    // ------------------------------------------------------------------
    localparam [2:0] S_OSC   = 3'h0;
    localparam [2:0] S_DRIVE = 3'h1;
    localparam [2:0] S_PIN   = 3'h2;
    localparam [2:0] S_DELAY = 3'h3;
    localparam [2:0] S_RUN   = 3'h4;

    localparam [15:0] OSC_CYC  = `OSC_START_CYC;
    localparam [15:0] WD_CYC   = `WDOG_CYC;
    localparam [15:0] BUS_CYC  = `BUS_DELAY_CYC;
    localparam [15:0] LOCK_MIN = `LOCK_MIN_CYC;

    // ------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------
    reg              pin_m_q;
    reg              pin_s_q;
    reg              bor_m_q;
    reg              bor_s_q;
    reg [BOOT_W-1:0] boot_m_q;
    reg [BOOT_W-1:0] boot_s_q;

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pin_m_q  <= 1'b1;
            pin_s_q  <= 1'b1;
            bor_m_q  <= 1'b0;
            bor_s_q  <= 1'b0;
            boot_m_q <= {BOOT_W{1'b0}};
            boot_s_q <= {BOOT_W{1'b0}};
        end else begin
            pin_m_q  <= reset_pin_n_in;
            pin_s_q  <= pin_m_q;
            bor_m_q  <= brownout_reset;
            bor_s_q  <= bor_m_q;
            boot_m_q <= boot_mode_pins;
            boot_s_q <= boot_m_q;
        end
    end

    // ------------------------------------------------------------------
    // Reset sequence
    // ------------------------------------------------------------------
    reg  [2:0]  st_q;
    reg  [15:0] cnt_q;
    wire        run = (st_q == S_RUN);

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_q         <= S_OSC;
            cnt_q        <= 16'h0000;
            boot_mode_q  <= {BOOT_W{1'b0}};
            boot_valid_q <= 1'b0;
        end else begin
            case (st_q)
                S_OSC: begin
                    // Nothing is timed off the oscillator before it settles
                    if (cnt_q == OSC_CYC - 16'h0001) begin
                        st_q  <= S_DRIVE;
                        cnt_q <= DRIVE_CYC - 16'h0001;
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                S_DRIVE: begin
                    if (!bor_s_q) begin
                        cnt_q <= DRIVE_CYC - 16'h0001;
                    end else if (cnt_q == 16'h0000) begin
                        st_q <= S_PIN;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                S_PIN: begin
                    // Waits out an external driver still holding the pin
                    if (!bor_s_q) begin
                        st_q  <= S_DRIVE;
                        cnt_q <= DRIVE_CYC - 16'h0001;
                    end else if (pin_s_q) begin
                        st_q  <= S_DELAY;
                        cnt_q <= BUS_CYC - 16'h0001;
                    end
                end
                S_DELAY: begin
                    if (!pin_s_q) begin
                        st_q <= S_PIN;
                    end else if (cnt_q == 16'h0000) begin
                        st_q         <= S_RUN;
                        boot_mode_q  <= boot_s_q;
                        boot_valid_q <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                S_RUN: begin
                    if (!bor_s_q) begin
                        st_q         <= S_DRIVE;
                        cnt_q        <= DRIVE_CYC - 16'h0001;
                        boot_valid_q <= 1'b0;
                    end else if (watchdog_req) begin
                        st_q         <= S_DRIVE;
                        cnt_q        <= WD_CYC - 16'h0001;
                        boot_valid_q <= 1'b0;
                    end else if (soft_reset_req) begin
                        st_q         <= S_DRIVE;
                        cnt_q        <= DRIVE_CYC - 16'h0001;
                        boot_valid_q <= 1'b0;
                    end else if (!pin_s_q) begin
                        st_q         <= S_PIN;
                        boot_valid_q <= 1'b0;
                    end
                end
                default: begin
                    st_q  <= S_OSC;
                    cnt_q <= 16'h0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Clock configuration and PLL lock
    // ------------------------------------------------------------------
    reg  [1:0]  system_clock_divide_select_q;
    reg  [1:0]  codiv_q;
    reg         coen_q;
    reg  [3:0]  pllm_q;
    reg         lock_q;
    reg  [15:0] lcnt_q;
    reg         booted_q;
    wire [15:0] lock_len = (intosc_sel && lock_prd_in < LOCK_MIN) ?
                           LOCK_MIN : lock_prd_in;

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            system_clock_divide_select_q <= `SYSTEM_CLOCK_DIVIDE_SELECT_RST;
            codiv_q  <= `CODIV_RST;
            coen_q   <= 1'b0;
            pllm_q   <= `PLLM_RST;
            lock_q   <= 1'b0;
            lcnt_q   <= 16'h0000;
            booted_q <= 1'b0;
        end else if (!run) begin
            // Every reset brings the clocks back to power-up defaults
            system_clock_divide_select_q <= `SYSTEM_CLOCK_DIVIDE_SELECT_RST;
            codiv_q  <= `CODIV_RST;
            coen_q   <= 1'b0;
            pllm_q   <= `PLLM_RST;
            lock_q   <= 1'b0;
            lcnt_q   <= 16'h0000;
            booted_q <= 1'b0;
        end else begin
            booted_q <= 1'b1;
            if (!booted_q) begin
                system_clock_divide_select_q <= `SYSTEM_CLOCK_DIVIDE_SELECT_DIV1;
            end else if (system_clock_divide_select_wr) begin
                system_clock_divide_select_q <= system_clock_divide_select_in;
            end
            if (codiv_wr) begin
                codiv_q <= codiv_in;
            end
            if (coen_wr) begin
                coen_q <= coen_in;
            end
            if (pllm_wr) begin
                pllm_q <= pllm_in;
                lock_q <= 1'b1;
                lcnt_q <= lock_len;
            end else if (lock_q) begin
                if (lcnt_q <= 16'h0001) begin
                    lock_q <= 1'b0;
                end else begin
                    lcnt_q <= lcnt_q - 16'h0001;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Clock mode and output divider
    // ------------------------------------------------------------------
    reg [1:0] mode_d;
    reg [4:0] sysf;
    reg [4:0] outf;
    reg [4:0] half_d;

    always @* begin
        if (lock_q) begin
            mode_d = `MODE_DIV2;
        end else if (pllm_q != `PLLM_RST) begin
            mode_d = `MODE_PLL;
        end else if (system_clock_divide_select_q == `SYSTEM_CLOCK_DIVIDE_SELECT_DIV1) begin
            mode_d = `MODE_DIV1;
        end else if (system_clock_divide_select_q == `SYSTEM_CLOCK_DIVIDE_SELECT_DIV2) begin
            mode_d = `MODE_DIV2;
        end else begin
            mode_d = `MODE_DIV4;
        end
        case (mode_d)
            `MODE_DIV4: sysf = 5'h04;
            `MODE_DIV2: sysf = 5'h02;
            default:    sysf = 5'h01;
        endcase
        case (codiv_q)
            `CODIV_DIV4: outf = 5'h04;
            `CODIV_DIV2: outf = 5'h02;
            default:     outf = 5'h01;
        endcase
        // Half period in oscillator cycles; faster than that is not
        // representable from this clock, so the pin then holds low
        if (mode_d == `MODE_PLL) begin
            half_d = 5'h00;
        end else begin
            half_d = ((sysf * outf) >> 1);
        end
    end

    reg [4:0] ph_q;
    reg       clk_q;

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ph_q          <= 5'h00;
            clk_q         <= 1'b0;
            sysclk_mode_q <= `MODE_DIV4;
            pll_ratio_q   <= 3'h0;
        end else if (ph_q == 5'h00) begin
            // New settings only take effect on a phase edge
            sysclk_mode_q <= mode_d;
            pll_ratio_q   <= pllm_q[3:1];
            if (half_d == 5'h00) begin
                clk_q <= 1'b0;
                ph_q  <= 5'h00;
            end else begin
                clk_q <= ~clk_q;
                ph_q  <= half_d - 5'h01;
            end
        end else begin
            ph_q <= ph_q - 5'h01;
        end
    end

    // ------------------------------------------------------------------
    // Output stage, all on the one clock
    // ------------------------------------------------------------------
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reset_pin_n_out   <= 1'b0;
            reset_pin_n_oe_n  <= 1'b1;
            pll_locking_q     <= 1'b0;
            clock_output_pin  <= 1'b0;
            clock_output_oe_n <= 1'b1;
            bus_valid_q       <= 1'b0;
            pull_enable_q     <= 1'b0;
        end else begin
            reset_pin_n_out   <= 1'b0;
            reset_pin_n_oe_n  <= ~(st_q == S_DRIVE);
            pll_locking_q     <= lock_q;
            clock_output_pin  <= coen_q & clk_q;
            clock_output_oe_n <= ~coen_q;
            bus_valid_q       <= run;
            pull_enable_q     <= bor_s_q;
        end
    end

    // Unprotected pins follow their source even through power events
    genvar i;
    generate
        for (i = 0; i < GPIO_W; i = i + 1) begin : g_gpio
            always @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    gpio_out[i]  <= 1'b0;
                    gpio_oe_n[i] <= 1'b1;
                end else if (run || UNPROT_MASK[i]) begin
                    gpio_out[i]  <= gpio_in[i];
                    gpio_oe_n[i] <= gpio_oe_n_in[i];
                end else begin
                    gpio_out[i]  <= 1'b0;
                    gpio_oe_n[i] <= 1'b1;
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// ---- rcs_asserts.sv ----
/*
 * Port checker for the reset and clock start-up sequencer.
 * Assumes one clock domain with resetn as its asynchronous reset.
 */
`timescale 1ns/100ps
`default_nettype none
`include "rst_seq_defs.vh"

module rcs_asserts #(
    parameter        BOOT_W    = 2,
    parameter [15:0] DRIVE_CYC = 16'h0028
) (
    // Clock and reset
    input wire logic              clock,
    input wire logic              resetn,
    // Pin, supervisor and requests
    input wire logic              reset_pin_n_in,
    input wire logic              reset_pin_n_out,
    input wire logic              reset_pin_n_oe_n,
    input wire logic              brownout_reset,
    input wire logic              watchdog_req,
    input wire logic              soft_reset_req,
    // Straps and status
    input wire logic [BOOT_W-1:0] boot_mode_pins,
    input wire logic [BOOT_W-1:0] boot_mode_q,
    input wire logic              boot_valid_q,
    input wire logic              pllm_wr,
    input wire logic [3:0]        pllm_in,
    input wire logic [1:0]        sysclk_mode_q,
    input wire logic              pll_locking_q,
    input wire logic              clock_output_pin,
    input wire logic              clock_output_oe_n,
    input wire logic              bus_valid_q,
    input wire logic              pull_enable_q
);
    // Watchdog pulse is fixed; the shorter of the two is the floor
    localparam int MIN_DRV = (DRIVE_CYC < 512) ? DRIVE_CYC : 512;
    logic [15:0] high_cnt_q;
    logic [15:0] drv_cnt_q;

    // ------------------------------------------------------------------
    // Run-length counters of pin high and pin drive
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            high_cnt_q <= 16'h0000;
            drv_cnt_q  <= 16'h0000;
        end else begin
            if (!reset_pin_n_in)
                high_cnt_q <= 16'h0000;
            else if (high_cnt_q != 16'hffff)
                high_cnt_q <= high_cnt_q + 16'h0001;
            if (reset_pin_n_oe_n)
                drv_cnt_q <= 16'h0000;
            else if (drv_cnt_q != 16'hffff)
                drv_cnt_q <= drv_cnt_q + 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    a_pin_data_low: assert property (
        reset_pin_n_out == 1'b0) else $error("reset pin data not low");
    a_drive_width: assert property (
        $rose(reset_pin_n_oe_n) |-> drv_cnt_q >= MIN_DRV)
        else $error("reset pin drive too short");
    a_bus_wait: assert property (
        $rose(bus_valid_q) |-> high_cnt_q >= 16'h0020)
        else $error("bus valid too soon after pin high");
    a_lock_start: assert property (
        pllm_wr && pllm_in != 4'h0 && bus_valid_q && !watchdog_req
        && !soft_reset_req |-> ##2 pll_locking_q)
        else $error("lock phase did not start");
    a_lock_half_rate: assert property (
        $rose(pll_locking_q) ##8 pll_locking_q |-> sysclk_mode_q == `MODE_DIV2)
        else $error("system clock not halved while locking");
    a_pll_after_lock: assert property (
        $fell(pll_locking_q) && bus_valid_q
        |-> ##[0:9] sysclk_mode_q == `MODE_PLL)
        else $error("multiplied clock not taken after lock");
    a_pull_off: assert property (
        !brownout_reset [*4] |=> !pull_enable_q)
        else $error("pulls enabled during brown-out");
    a_pull_on: assert property (
        brownout_reset [*4] |=> pull_enable_q)
        else $error("pulls not enabled with supply good");
    a_clkout_quiet: assert property (
        clock_output_oe_n |-> !clock_output_pin)
        else $error("clock output toggles while disabled");
    a_strap_hold: assert property (
        $rose(boot_valid_q) |-> boot_mode_q == boot_mode_pins)
        else $error("captured straps differ from pins");

    c_lock: cover property ($rose(pll_locking_q));
    c_run: cover property ($rose(bus_valid_q));
    c_drive: cover property ($fell(reset_pin_n_oe_n));
endmodule

bind reset_clock_sequencer rcs_asserts #(
    .BOOT_W(BOOT_W), .DRIVE_CYC(DRIVE_CYC)) chk (
    .clock, .resetn, .reset_pin_n_in, .reset_pin_n_out, .reset_pin_n_oe_n,
    .brownout_reset, .watchdog_req, .soft_reset_req, .boot_mode_pins,
    .boot_mode_q, .boot_valid_q, .pllm_wr, .pllm_in, .sysclk_mode_q,
    .pll_locking_q, .clock_output_pin, .clock_output_oe_n, .bus_valid_q,
    .pull_enable_q);
`default_nettype wire

// ---- ext_reset_model.sv ----
/*
 * Board side: external reset source on the pulled-up reset pin and the
 * boot-mode straps. Assumes the device drives the pin open drain.
 */
`timescale 1ns/100ps
`default_nettype none

module ext_reset_model #(
    parameter int BOOT_W   = 2,
    parameter int WARM_CYC = 32
) (
    input  wire logic              clock,
    input  wire logic              reset_pin_n_oe_n,
    input  wire logic              warm_go,
    input  wire logic [BOOT_W-1:0] strap_sel,
    output wire logic              reset_pin_n_in,
    output var  logic [BOOT_W-1:0] boot_mode_pins
);
    int unsigned low_cnt = 0;

    initial boot_mode_pins = '0;

    always @(posedge clock) begin
        if (warm_go)
            low_cnt <= WARM_CYC;
        else if (low_cnt != 0)
            low_cnt <= low_cnt - 1;
    end

    // Pull-up wins unless either party pulls the pin low
    assign reset_pin_n_in = reset_pin_n_oe_n && low_cnt == 0;

    // Straps move only in reset, so they stand long after release
    always @(posedge clock) begin
        if (!reset_pin_n_in)
            boot_mode_pins <= strap_sel;
    end
endmodule
`default_nettype wire

// ---- reset_and_clock_startup_sequencer_tb.sv ----
/*
 * Self-checking bench for the reset and clock start-up sequencer.
 * Assumes a 20 MHz clock and a shortened device pin pulse of 40 cycles.
 */
`timescale 1ns/100ps
`default_nettype none
`include "rst_seq_defs.vh"

module reset_and_clock_startup_sequencer_tb;
    localparam int DRV = 40;
    logic clock = 1'b0, resetn = 1'b0, brownout_reset = 1'b1;
    logic watchdog_req = 1'b0, soft_reset_req = 1'b0, warm_go = 1'b0;
    logic system_clock_divide_select_wr = 1'b0, codiv_wr = 1'b0, coen_wr = 1'b0;
    logic pllm_wr = 1'b0, coen_in = 1'b0, intosc_sel = 1'b0;
    logic [1:0] system_clock_divide_select_in = 2'h0, codiv_in = 2'h0, strap_sel = 2'h1;
    logic [3:0] pllm_in = 4'h0;
    logic [15:0] lock_prd_in = 16'h0064;
    logic [7:0] gpio_in = 8'ha5, gpio_oe_n_in = 8'h0f;
    wire reset_pin_n_in, reset_pin_n_out, reset_pin_n_oe_n, boot_valid_q;
    wire pll_locking_q, clock_output_pin, clock_output_oe_n;
    wire bus_valid_q, pull_enable_q;
    wire [1:0] boot_mode_pins, boot_mode_q, sysclk_mode_q;
    wire [2:0] pll_ratio_q;
    wire [7:0] gpio_out, gpio_oe_n;
    int errors = 0, comparisons = 0, n;

    always #25 clock = ~clock;

    reset_clock_sequencer #(.DRIVE_CYC(16'h0028)) dut (
        .clock, .resetn, .reset_pin_n_in, .reset_pin_n_out,
        .reset_pin_n_oe_n, .brownout_reset, .watchdog_req, .soft_reset_req,
        .boot_mode_pins, .boot_mode_q, .boot_valid_q, .system_clock_divide_select_wr,
        .system_clock_divide_select_in, .codiv_wr, .codiv_in, .coen_wr, .coen_in, .pllm_wr,
        .pllm_in, .lock_prd_in, .intosc_sel, .sysclk_mode_q, .pll_ratio_q,
        .pll_locking_q, .clock_output_pin, .clock_output_oe_n, .bus_valid_q,
        .pull_enable_q, .gpio_in, .gpio_oe_n_in, .gpio_out, .gpio_oe_n);

    ext_reset_model peer (.clock, .reset_pin_n_oe_n, .warm_go, .strap_sel,
        .reset_pin_n_in, .boot_mode_pins);

    // ------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------
    function automatic logic sig(input int s);
        case (s)
            0: return reset_pin_n_oe_n;
            1: return bus_valid_q;
            default: return pll_locking_q;
        endcase
    endfunction

    task automatic tick();
        @(posedge clock);
        #1;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Bounded wait; n ends as the number of edges waited
    task automatic wait_for(input int s, input logic v, input int lim);
        n = 0;
        while (sig(s) !== v && n < lim) begin
            tick();
            n++;
        end
        check(n < lim, 1'b1);
    endtask

    task automatic cfg(input int w, input logic [3:0] v);
        @(posedge clock);
        case (w)
            0: begin system_clock_divide_select_wr <= 1'b1; system_clock_divide_select_in <= v[1:0]; end
            1: begin codiv_wr <= 1'b1; codiv_in <= v[1:0]; end
            2: begin coen_wr <= 1'b1; coen_in <= v[0]; end
            default: begin pllm_wr <= 1'b1; pllm_in <= v; end
        endcase
        @(posedge clock);
        {system_clock_divide_select_wr, codiv_wr, coen_wr, pllm_wr} <= 4'h0;
    endtask

    task automatic print_verdict();
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_power_up();
        check(gpio_oe_n, 8'hff);
        check(sysclk_mode_q, `MODE_DIV4);
        @(posedge clock) resetn <= 1'b1;
        #1;
        wait_for(0, 1'b0, 200);
        check(n >= 58 && n <= 64, 1'b1);
        check(sysclk_mode_q, `MODE_DIV4);
        wait_for(0, 1'b1, 100);
        check(n, DRV);
        wait_for(1, 1'b1, 100);
        check(n >= 32 && n <= 40, 1'b1);
        check(boot_mode_q, 2'h1);
        repeat (10) tick();
        check(sysclk_mode_q, `MODE_DIV1);
        check(clock_output_oe_n, 1'b1);
        check({gpio_out, gpio_oe_n}, 16'ha50f);
        $display("power-up test done");
    endtask

    task automatic t_clock_out(input logic [1:0] ds, input logic [1:0] cd,
                               input int win, input int rises);
        int r;
        logic prev;
        cfg(0, ds);
        cfg(1, cd);
        cfg(2, 4'h1);
        repeat (20) tick();
        check(clock_output_oe_n, 1'b0);
        r = 0;
        prev = clock_output_pin;
        repeat (win) begin
            tick();
            r += int'(clock_output_pin & !prev);
            prev = clock_output_pin;
        end
        check(r, rises);
        $display("clock output test done");
    endtask

    task automatic t_pll(input logic [3:0] m, input logic osc,
                         input int lo, input int hi);
        @(posedge clock) intosc_sel <= osc;
        cfg(3, m);
        tick();
        tick();
        check(pll_locking_q, 1'b1);
        repeat (10) tick();
        check(sysclk_mode_q, `MODE_DIV2);
        wait_for(2, 1'b0, 10100);
        check(n + 12 >= lo && n + 12 <= hi, 1'b1);
        repeat (12) tick();
        check(sysclk_mode_q, `MODE_PLL);
        check(pll_ratio_q, m[3:1]);
        $display("pll test done");
    endtask

    task automatic t_drive(input logic wd, input logic sr, input int len);
        @(posedge clock);
        watchdog_req <= wd;
        soft_reset_req <= sr;
        @(posedge clock);
        watchdog_req <= 1'b0;
        soft_reset_req <= 1'b0;
        #1;
        wait_for(0, 1'b0, 10);
        wait_for(0, 1'b1, 600);
        check(n, len);
        check(sysclk_mode_q, `MODE_DIV4);
        check(clock_output_oe_n, 1'b1);
        wait_for(1, 1'b1, 100);
        repeat (10) tick();
        $display("pin drive test done");
    endtask

    task automatic t_warm();
        @(posedge clock);
        strap_sel <= 2'h2;
        warm_go <= 1'b1;
        @(posedge clock);
        warm_go <= 1'b0;
        #1;
        wait_for(1, 1'b0, 10);
        wait_for(1, 1'b1, 800);
        check({boot_valid_q, boot_mode_q}, 3'h6);
        $display("warm reset test done");
    endtask

    task automatic t_brownout();
        @(posedge clock) brownout_reset <= 1'b0;
        repeat (6) tick();
        check({pull_enable_q, bus_valid_q}, 2'h0);
        repeat (100) tick();
        check(bus_valid_q, 1'b0);
        @(posedge clock) brownout_reset <= 1'b1;
        #1;
        wait_for(1, 1'b1, 800);
        check(pull_enable_q, 1'b1);
        $display("brown-out test done");
    endtask

    initial begin
        repeat (3) @(posedge clock);
        t_power_up();
        t_clock_out(2'h3, 2'h0, 40, 10);
        t_clock_out(2'h3, 2'h1, 40, 20);
        t_clock_out(2'h0, 2'h0, 64, 4);
        cfg(0, 4'h3);
        t_pll(4'h4, 1'b0, 98, 104);
        t_pll(4'h8, 1'b0, 98, 104);
        t_pll(4'h4, 1'b1, 10000, 10006);
        @(posedge clock) intosc_sel <= 1'b0;
        t_drive(1'b1, 1'b1, 512);
        t_drive(1'b0, 1'b1, DRV);
        t_warm();
        t_brownout();
        print_verdict();
    end

    initial begin
        repeat (30000) @(posedge clock);
        errors++;
        $display("watchdog expired");
        print_verdict();
    end
endmodule
`default_nettype wire
